// *** hw/gevb_cascade.sv ***
// Second-level status and enable bits that fan into one shared event input
`timescale 1ns/100ps
`default_nettype none
module gevb_cascade #(
  parameter int WIDTH = 4
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] src,
  input wire logic [WIDTH-1:0] en_wr,
  input wire logic [WIDTH-1:0] en_data,
  input wire logic [WIDTH-1:0] sts_clr,
  output logic [WIDTH-1:0] sts_r,
  output logic [WIDTH-1:0] en_r,
  output logic any_r
);
  import gevb_pkg::*;

  logic [WIDTH-1:0] sts_nxt;

  always_comb begin
    sts_nxt = (sts_r & ~sts_clr) | src;
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      sts_r <= '0;
      en_r <= '0;
      any_r <= 1'b0;
    end else begin
      sts_r <= sts_nxt;
      en_r <= (en_r & ~en_wr) | (en_data & en_wr);
      any_r <= |(sts_r & en_r);
    end
  end
endmodule
`default_nettype wire

// *** hw/gevb_pkg.sv ***
// Shared constants and carrier types for the general event block
package gevb_pkg;
  localparam int GEVB_MAX_INPUTS = 255;
  localparam int GEVB_FIRST_LEN = 8;
  localparam int GEVB_SECOND_LEN = 8;
  localparam logic [7:0] GEVB_SECOND_BASE = 8'h10;
  localparam int GEVB_EC_INDEX = 0;
  localparam int GEVB_CASCADE_INDEX = 1;
  localparam int GEVB_CASCADE_WIDTH = 4;
  localparam logic GEVB_STATUS_RESET = 1'h0;
  localparam logic GEVB_ENABLE_RESET = 1'h0;
  localparam int GEVB_TOTAL = GEVB_FIRST_LEN + GEVB_SECOND_LEN;

  typedef struct packed {
    logic wr;
    logic [7:0] index;
    logic set_enable;
    logic clear_status;
  } gevb_cmd_type;

  typedef enum logic [1:0] {
    GEVB_WORKING = 2'h0,
    GEVB_SLEEPING = 2'h1,
    GEVB_WAKING = 2'h2
  } gevb_power_type;
endpackage

// *** hw/gevb_top.sv ***
// General event block: latching status, enables, interrupt and wake request
`timescale 1ns/100ps
`default_nettype none
module gevb_top
  import gevb_pkg::*;
#(
  parameter int FIRST_LEN = gevb_pkg::GEVB_FIRST_LEN,
  parameter int SECOND_LEN = gevb_pkg::GEVB_SECOND_LEN,
  parameter logic [7:0] SECOND_BASE = gevb_pkg::GEVB_SECOND_BASE,
  parameter logic [gevb_pkg::GEVB_TOTAL-1:0] EDGE_TYPE = '0,
  parameter int CASCADE_WIDTH = gevb_pkg::GEVB_CASCADE_WIDTH
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [gevb_pkg::GEVB_TOTAL-1:0] event_in,
  input wire logic ec_iface_irq,
  input wire logic ec_service_req,
  input wire logic [CASCADE_WIDTH-1:0] cascade_src,
  input wire logic [CASCADE_WIDTH-1:0] cascade_en_wr,
  input wire logic [CASCADE_WIDTH-1:0] cascade_en_data,
  input wire logic [CASCADE_WIDTH-1:0] cascade_sts_clr,
  input wire gevb_pkg::gevb_cmd_type cmd,
  input wire logic system_sleeping,
  output logic [gevb_pkg::GEVB_TOTAL-1:0] general_event_status_bit,
  output logic [gevb_pkg::GEVB_TOTAL-1:0] general_event_enable_bit,
  output logic [CASCADE_WIDTH-1:0] cascade_status,
  output logic [CASCADE_WIDTH-1:0] cascade_enable,
  output logic system_control_interrupt,
  output logic wake_request
);
  import gevb_pkg::*;

  localparam int TOTAL = GEVB_TOTAL;

  // True when an index falls inside the first block
  function automatic logic in_first(input logic [7:0] idx);
    return int'(idx) < FIRST_LEN;
  endfunction

  // True when an index falls inside the second block
  function automatic logic in_second(input logic [7:0] idx);
    return idx >= SECOND_BASE && int'(idx) < int'(SECOND_BASE) + SECOND_LEN;
  endfunction

  // Maps an event index to a bit position; returns TOTAL for no match
  function automatic int index_to_bit(input logic [7:0] idx);
    int pos;
    pos = TOTAL;
    if (in_first(idx)) begin
      pos = int'(idx);
    end
    if (in_second(idx)) begin
      pos = FIRST_LEN + int'(idx) - int'(SECOND_BASE);
    end
    return pos;
  endfunction

  // Pending test shared by the interrupt and the wake tracker
  function automatic logic any_enabled(input logic [TOTAL-1:0] s, input logic [TOTAL-1:0] e);
    return |(s & e);
  endfunction

  logic [TOTAL-1:0] in_s1_r;
  logic [TOTAL-1:0] in_s2_r;
  logic [TOTAL-1:0] in_prev_r;
  logic ec_s1_r;
  logic ec_s2_r;
  logic svc_s1_r;
  logic svc_s2_r;
  logic [CASCADE_WIDTH-1:0] csrc_s1_r;
  logic [CASCADE_WIDTH-1:0] csrc_s2_r;
  logic sleep_s1_r;
  logic sleep_s2_r;
  logic cascade_any;
  logic [TOTAL-1:0] raw;
  logic [TOTAL-1:0] hit;
  logic [TOTAL-1:0] clr;
  logic [TOTAL-1:0] en_wr;
  logic [TOTAL-1:0] sts_nxt;
  logic [TOTAL-1:0] en_nxt;
  int cmd_bit;
  logic cmd_mapped;
  logic pend_nxt;
  gevb_power_type pwr_r;
  gevb_power_type pwr_nxt;

  // Event, controller, cascade source and sleep pins cross in through two flops before use
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      in_s1_r <= '0;
      in_s2_r <= '0;
    end else begin
      in_s1_r <= event_in;
      in_s2_r <= in_s1_r;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ec_s1_r <= 1'b0;
      ec_s2_r <= 1'b0;
    end else begin
      ec_s1_r <= ec_iface_irq;
      ec_s2_r <= ec_s1_r;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      svc_s1_r <= 1'b0;
      svc_s2_r <= 1'b0;
    end else begin
      svc_s1_r <= ec_service_req;
      svc_s2_r <= svc_s1_r;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      csrc_s1_r <= '0;
      csrc_s2_r <= '0;
    end else begin
      csrc_s1_r <= cascade_src;
      csrc_s2_r <= csrc_s1_r;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      sleep_s1_r <= 1'b0;
      sleep_s2_r <= 1'b0;
    end else begin
      sleep_s1_r <= system_sleeping;
      sleep_s2_r <= sleep_s1_r;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      in_prev_r <= '0;
    end else begin
      in_prev_r <= raw;
    end
  end

  gevb_cascade #(
    .WIDTH(CASCADE_WIDTH)
  ) u_cascade (
    .mclk(mclk),
    .rstn(rstn),
    .src(csrc_s2_r),
    .en_wr(cascade_en_wr),
    .en_data(cascade_en_data),
    .sts_clr(cascade_sts_clr),
    .sts_r(cascade_status),
    .en_r(cascade_enable),
    .any_r(cascade_any)
  );

  // Source levels per input; controller and cascade own their inputs alone
  always_comb begin
    raw = in_s2_r;
    raw[GEVB_EC_INDEX] = ec_s2_r | svc_s2_r;
    raw[GEVB_CASCADE_INDEX] = cascade_any;
  end

  genvar g;
  generate
    for (g = 0; g < TOTAL; g++) begin : g_hit
      if (EDGE_TYPE[g]) begin : g_edge
        assign hit[g] = raw[g] & ~in_prev_r[g];
      end else begin : g_level
        assign hit[g] = raw[g];
      end
    end
  endgenerate

  // Command decode to one-hot bit masks
  always_comb begin
    clr = '0;
    en_wr = '0;
    cmd_bit = index_to_bit(cmd.index);
    // Unmapped indices are ignored silently, as software expects
    cmd_mapped = in_first(cmd.index) || in_second(cmd.index);
    if (cmd.wr && cmd_mapped) begin
      clr[cmd_bit] = cmd.clear_status;
      en_wr[cmd_bit] = 1'b1;
    end
  end

  // event hits set status
  // Set wins over a clear in the same cycle so no event is lost
  always_comb begin
    sts_nxt = (general_event_status_bit & ~clr) | hit;
  end

  always_comb begin
    en_nxt = (general_event_enable_bit & ~en_wr) | ({TOTAL{cmd.set_enable}} & en_wr);
  end

  always_comb begin
    pend_nxt = any_enabled(sts_nxt, en_nxt);
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      general_event_status_bit <= {TOTAL{GEVB_STATUS_RESET}};
    end else begin
      general_event_status_bit <= sts_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      general_event_enable_bit <= {TOTAL{GEVB_ENABLE_RESET}};
    end else begin
      general_event_enable_bit <= en_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      system_control_interrupt <= 1'b0;
    end else begin
      system_control_interrupt <= pend_nxt;
    end
  end

  // sleep and wake tracker
  // Only the platform ends sleep; this block merely asks for it
  always_comb begin
    pwr_nxt = pwr_r;
    case (pwr_r)
      GEVB_WORKING: begin
        if (sleep_s2_r && pend_nxt) begin
          pwr_nxt = GEVB_WAKING;
        end else if (sleep_s2_r) begin
          pwr_nxt = GEVB_SLEEPING;
        end
      end
      GEVB_SLEEPING: begin
        if (!sleep_s2_r) begin
          pwr_nxt = GEVB_WORKING;
        end else if (pend_nxt) begin
          pwr_nxt = GEVB_WAKING;
        end
      end
      GEVB_WAKING: begin
        if (!sleep_s2_r) begin
          pwr_nxt = GEVB_WORKING;
        end else if (!pend_nxt) begin
          pwr_nxt = GEVB_SLEEPING;
        end
      end
      default: begin
        pwr_nxt = GEVB_WORKING;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pwr_r <= GEVB_WORKING;
    end else begin
      pwr_r <= pwr_nxt;
    end
  end

  // wake request level
  // Dropped as soon as nothing enabled is pending or sleep ends
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      wake_request <= 1'b0;
    end else begin
      wake_request <= (pwr_nxt == GEVB_WAKING);
    end
  end
endmodule
`default_nettype wire

// *** verification/gevb_assertions.sv ***
// Port checker for the general event block
`timescale 1ns/100ps
`default_nettype none
module gevb_assertions
  import gevb_pkg::*;
#(
  parameter int CASCADE_WIDTH = 4
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [gevb_pkg::GEVB_TOTAL-1:0] event_in,
  input wire logic ec_iface_irq,
  input wire logic [CASCADE_WIDTH-1:0] cascade_src,
  input wire gevb_pkg::gevb_cmd_type cmd,
  input wire logic [gevb_pkg::GEVB_TOTAL-1:0] general_event_status_bit,
  input wire logic [gevb_pkg::GEVB_TOTAL-1:0] general_event_enable_bit,
  input wire logic [CASCADE_WIDTH-1:0] cascade_enable,
  input wire logic system_control_interrupt,
  input wire logic wake_request
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  wire logic [GEVB_TOTAL-1:0] st = general_event_status_bit;
  wire logic [GEVB_TOTAL-1:0] en = general_event_enable_bit;
  wire logic wr5 = cmd.wr && cmd.index == 8'h05;
  sequence s_ev5; $rose(event_in[5]) ##1 event_in[5] [*2]; endsequence
  sequence s_ec; $rose(ec_iface_irq) ##1 ec_iface_irq [*2]; endsequence
  sequence s_casc; (cascade_src[0] && cascade_enable[0]) [*3]; endsequence
  a_irq_level: assert property (system_control_interrupt == |(st & en))
    else $error("interrupt differs from enabled status");
  a_wake_irq: assert property (wake_request |-> system_control_interrupt)
    else $error("wake without enabled status");
  a_event_latch: assert property (s_ev5 |-> ##[0:2] st[5])
    else $error("event did not set status");
  a_ec_status: assert property (s_ec |-> ##[0:2] st[0])
    else $error("controller status not set");
  a_cascade_sum: assert property (s_casc |-> ##[0:4] st[1])
    else $error("cascade did not reach shared bit");
  a_clear_cause: assert property ($fell(st[5]) |-> $past(wr5 && cmd.clear_status))
    else $error("status fell without clear");
  a_zero_keeps: assert property (wr5 && !cmd.clear_status && st[5] |=> st[5])
    else $error("zero write cleared status");
  a_enable_write: assert property (wr5 |=> en[5] == $past(cmd.set_enable))
    else $error("enable write lost");
  a_second_base: assert property (cmd.wr && cmd.index == GEVB_SECOND_BASE
    |=> en[8] == $past(cmd.set_enable))
    else $error("base index not on second block");
  a_unmapped: assert property (cmd.wr && cmd.index == 8'h08 |=> $stable(en))
    else $error("unmapped index changed enables");
endmodule
bind gevb_top gevb_assertions #(.CASCADE_WIDTH(CASCADE_WIDTH)) gevb_assertions_inst (
  .mclk(mclk), .rstn(rstn), .event_in(event_in), .ec_iface_irq(ec_iface_irq),
  .cascade_src(cascade_src), .cmd(cmd), .general_event_status_bit(general_event_status_bit),
  .general_event_enable_bit(general_event_enable_bit), .cascade_enable(cascade_enable),
  .system_control_interrupt(system_control_interrupt), .wake_request(wake_request));
`default_nettype wire

// *** verification/gevb_host_model.sv ***
// Host driver model issuing block commands
`timescale 1ns/100ps
`default_nettype none
module gevb_host_model
  import gevb_pkg::*;
(
  input wire logic mclk,
  output var gevb_pkg::gevb_cmd_type cmd
);
  initial cmd = '0;
  task automatic send(input logic [7:0] i, input logic e, input logic c);
    @(negedge mclk);
    cmd = {1'h1, i, e, c};
  endtask
  task automatic idle();
    @(negedge mclk);
    cmd = '0;
  endtask
  task automatic service(input logic [7:0] i, input logic e_t);
    send(i, 1'h0, 1'h0);
    if (e_t) send(i, 1'h0, 1'h1);
    idle();
    if (!e_t) send(i, 1'h0, 1'h1);
    send(i, 1'h1, 1'h0);
    idle();
  endtask
endmodule
`default_nettype wire

// *** verification/tb.sv ***
// Self-checking bench for the general event block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; \
  $display("mismatch t=%0t got=%0h exp=%0h", $time, a, b); end end
module tb;
  import gevb_pkg::*;
  logic mclk = 0, rstn = 0, ec_irq = 0, ec_svc = 0, sleep = 0;
  logic [15:0] ev = '0;
  logic [3:0] c_src = '0, c_wr = '0, c_dat = '0, c_clr = '0;
  wire gevb_cmd_type cmd;
  wire logic [15:0] st, en;
  wire logic [3:0] c_st, c_en;
  wire logic irq, wake;
  int err_total = 0, n_checks = 0;
  gevb_top #(.EDGE_TYPE(16'h0040)) gevb_top_inst (.mclk(mclk), .rstn(rstn), .event_in(ev),
    .ec_iface_irq(ec_irq), .ec_service_req(ec_svc), .cascade_src(c_src), .cascade_en_wr(c_wr),
    .cascade_en_data(c_dat), .cascade_sts_clr(c_clr), .cmd(cmd), .system_sleeping(sleep),
    .general_event_status_bit(st), .general_event_enable_bit(en), .cascade_status(c_st),
    .cascade_enable(c_en), .system_control_interrupt(irq), .wake_request(wake));
  gevb_host_model gevb_host_model_inst (.mclk(mclk), .cmd(cmd));
  initial forever #10 mclk = ~mclk;
  task automatic print_verdict();
    if (err_total == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // Inputs pass two sync stages, so allow a short bounded wait
  task automatic wait_st(input int b);
    int k;
    for (k = 0; k < 12 && st[b] !== 1'h1; k++) @(negedge mclk);
    if (k == 12) begin
      err_total++;
      print_verdict();
    end
  endtask
  task automatic set_all(input logic v);
    for (int i = 0; i < 16; i++) begin
      gevb_host_model_inst.send(i < 8 ? 8'(i) : 8'(i + 8), v, 1'h0);
    end
    gevb_host_model_inst.send(8'h08, 1'h0, 1'h0);
    gevb_host_model_inst.send(8'h18, 1'h0, 1'h0);
    gevb_host_model_inst.idle();
    `CHK(en, {16{v}})
  endtask
  task automatic clr(input logic [7:0] i);
    gevb_host_model_inst.send(i, 1'h0, 1'h1);
    gevb_host_model_inst.idle();
  endtask
  task automatic t_level();
    sleep = 1'h1;
    gevb_host_model_inst.send(8'h05, 1'h1, 1'h0);
    ev[5] = 1'h1;
    wait_st(5);
    cyc(1);
    `CHK({irq, wake}, 2'h3)
    ev[5] = 1'h0;
    sleep = 1'h0;
    gevb_host_model_inst.idle();
    cyc(4);
    `CHK({st[5], wake}, 2'h2)
    gevb_host_model_inst.service(8'h05, 1'h0);
    `CHK({st[5], en[5], irq}, 3'h2)
    ev[5] = 1'h1;
    wait_st(5);
    clr(8'h05);
    cyc(2);
    `CHK(st[5], 1'h1)
    ev[5] = 1'h0;
    cyc(4);
    clr(8'h05);
    `CHK(st, 16'h0000)
  endtask
  task automatic t_edge();
    ev[6] = 1'h1;
    wait_st(6);
    clr(8'h06);
    cyc(3);
    `CHK(st[6], 1'h0)
    ev[6] = 1'h0;
    cyc(3);
    ev[6] = 1'h1;
    wait_st(6);
    ev[6] = 1'h0;
    clr(8'h06);
    `CHK(st[6], 1'h0)
  endtask
  task automatic t_ec();
    ev[0] = 1'h1;
    cyc(5);
    `CHK(st[0], 1'h0)
    ev[0] = 1'h0;
    ec_irq = 1'h1;
    wait_st(0);
    ec_irq = 1'h0;
    cyc(3);
    clr(8'h00);
    ec_svc = 1'h1;
    wait_st(0);
    ec_svc = 1'h0;
    cyc(3);
    clr(8'h00);
    `CHK(st[0], 1'h0)
  endtask
  task automatic t_casc();
    c_wr = 4'h1;
    c_dat = 4'h1;
    cyc(1);
    c_wr = 4'h0;
    `CHK(c_en, 4'h1)
    c_src = 4'h3;
    wait_st(1);
    `CHK(c_st, 4'h3)
    c_src = 4'h0;
    cyc(3);
    c_clr = 4'h3;
    cyc(1);
    c_clr = 4'h0;
    `CHK(c_st, 4'h0)
    cyc(2);
    clr(8'h01);
    `CHK(st[1], 1'h0)
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    @(negedge mclk);
    rstn = 1'h1;
    cyc(3);
    `CHK({st, en, irq, wake}, 34'h0)
    set_all(1'h1);
    set_all(1'h0);
    t_level();
    t_edge();
    t_ec();
    t_casc();
    print_verdict();
  end
endmodule
`default_nettype wire
